// ---- design/tlic_top.v ----
/*
 two-level interrupt controller: control bits, vectoring, return handling.
 assumes the core takes vector_o on take_o, pushes the return address
 itself, and pulses ret_instr_i when the return instruction executes.
*/
`timescale 1ns/1ps
`include "tlic_regs.vh"

module tlic_top (
  input  wire                      clock_i,
  input  wire                      rst_i,
  input  wire [`TLIC_NSRC-1:0]     event_i,
  input  wire [`TLIC_NSRC-1:0]     flag_clear_i,
  input  wire [`TLIC_NSRC-1:0]     enable_i,
  input  wire [`TLIC_NSRC-1:0]     prio_i,
  input  wire [`TLIC_NSRC-1:0]     periph_i,
  input  wire [`TLIC_NSRC-1:0]     external_i,
  input  wire                      reset_ctl_wr_i,
  input  wire [7:0]                reset_ctl_data_i,
  input  wire                      int_ctl_wr_i,
  input  wire [7:0]                int_ctl_data_i,
  input  wire                      ret_instr_i,
  output reg  [`TLIC_NSRC-1:0]     flag_o,
  output reg                       priority_levels_enable_o,
  output reg                       high_level_global_enable_o,
  output reg                       low_level_global_enable_o,
  output reg                       take_o,
  output reg  [`TLIC_PC_W-1:0]     vector_o,
  output reg                       in_high_o,
  output reg                       in_low_o
);
  reg                    pen_ff;
  reg                    gie7_ff;
  reg                    gie6_ff;
  reg                    in_high_ff;
  reg                    in_low_ff;
  reg                    take_ff;
  reg [`TLIC_PC_W-1:0]   vec_ff;
  reg                    wait_ff;
  reg [`TLIC_LAT_W-1:0]  lat_ff;
  reg                    nxt_gie7;
  reg                    nxt_gie6;
  reg                    nxt_in_high;
  reg                    nxt_in_low;
  wire [`TLIC_NSRC-1:0]  flags;
  wire [1:0]             level;
  wire                   ext_now;
  wire                   ext_hold;

  tlic_flags u_flags (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .event_i (event_i),
    .clear_i (flag_clear_i),
    .flag_o  (flags)
  );

  tlic_arb u_arb (
    .flag_i    (flags),
    .enable_i  (enable_i),
    .prio_i    (prio_i),
    .periph_i  (periph_i),
    .pen_i     (pen_ff),
    .bit7_i    (gie7_ff),
    .bit6_i    (gie6_ff),
    .in_high_i (in_high_ff),
    .level_o   (level)
  );

  // an external event holds off vectoring for a fixed count so that the
  // latency never varies with the length of the interrupted instruction
  assign ext_now  = |(event_i & external_i);
  assign ext_hold = wait_ff & (lat_ff != `TLIC_EXT_LAT_CLK - 1);

  always @(posedge clock_i) begin
    if (rst_i) begin
      wait_ff <= 1'b0;
      lat_ff  <= {`TLIC_LAT_W{1'b0}};
    end else if (ext_now & ~wait_ff) begin
      wait_ff <= 1'b1;
      lat_ff  <= {`TLIC_LAT_W{1'b0}};
    end else if (wait_ff) begin
      lat_ff  <= lat_ff + 1'b1;
      if (~ext_hold) begin
        wait_ff <= 1'b0;
      end
    end
  end

  always @* begin
    nxt_gie7    = gie7_ff;
    nxt_gie6    = gie6_ff;
    nxt_in_high = in_high_ff;
    nxt_in_low  = in_low_ff;
    if (int_ctl_wr_i) begin
      nxt_gie7 = int_ctl_data_i[`TLIC_HIGH_EN_BIT];
      nxt_gie6 = int_ctl_data_i[`TLIC_LOW_EN_BIT];
    end
    if (ret_instr_i) begin
      // re-enable the level being left, innermost first
      if (~pen_ff) begin
        nxt_gie7 = 1'b1;
        nxt_in_high = 1'b0;
      end else if (in_high_ff) begin
        nxt_gie7 = 1'b1;
        nxt_in_high = 1'b0;
      end else begin
        nxt_gie6 = 1'b1;
        nxt_in_low = 1'b0;
      end
    end
    if (~ext_hold) begin
      // hardware accept overrides a same-cycle software write
      case (level)
        `TLIC_LVL_HIGH: begin
          nxt_gie7    = 1'b0;
          nxt_in_high = 1'b1;
        end
        `TLIC_LVL_LOW: begin
          nxt_gie6   = 1'b0;
          nxt_in_low = 1'b1;
        end
        default: begin
          nxt_in_high = nxt_in_high;
        end
      endcase
    end
  end

  always @(posedge clock_i) begin
    if (rst_i) begin
      pen_ff     <= `TLIC_PEN_RST;
      gie7_ff    <= 1'b0;
      gie6_ff    <= 1'b0;
      in_high_ff <= 1'b0;
      in_low_ff  <= 1'b0;
      take_ff    <= 1'b0;
      vec_ff     <= `TLIC_VEC_HIGH;
    end else begin
      if (reset_ctl_wr_i) begin
        pen_ff <= reset_ctl_data_i[`TLIC_PEN_BIT];
      end
      gie7_ff    <= nxt_gie7;
      gie6_ff    <= nxt_gie6;
      in_high_ff <= nxt_in_high;
      in_low_ff  <= nxt_in_low;
      take_ff    <= (level != `TLIC_LVL_NONE) & ~ext_hold;
      // vector moves only with an accept, never during a latency hold
      if (level == `TLIC_LVL_LOW && ~ext_hold) begin
        vec_ff <= `TLIC_VEC_LOW;
      end else if (level == `TLIC_LVL_HIGH && ~ext_hold) begin
        vec_ff <= `TLIC_VEC_HIGH;
      end
    end
  end

  always @(posedge clock_i) begin
    if (rst_i) begin
      flag_o                     <= {`TLIC_NSRC{1'b0}};
      priority_levels_enable_o   <= 1'b0;
      high_level_global_enable_o <= 1'b0;
      low_level_global_enable_o  <= 1'b0;
      take_o                     <= 1'b0;
      vector_o                   <= `TLIC_VEC_HIGH;
      in_high_o                  <= 1'b0;
      in_low_o                   <= 1'b0;
    end else begin
      flag_o                     <= flags;
      priority_levels_enable_o   <= pen_ff;
      high_level_global_enable_o <= gie7_ff;
      low_level_global_enable_o  <= gie6_ff;
      take_o                     <= take_ff;
      vector_o                   <= vec_ff;
      in_high_o                  <= in_high_ff;
      in_low_o                   <= in_low_ff;
    end
  end
endmodule

// ---- common/tlic_regs.vh ----
/*
 constants for the two-level interrupt controller: vectors, bit positions
 of the control bits, source count and latency figures.
 assumes nothing; definitions only.
*/
`ifndef TLIC_REGS_VH
`define TLIC_REGS_VH

`define TLIC_NSRC          8
`define TLIC_PC_W          21
`define TLIC_VEC_HIGH      21'h000008
`define TLIC_VEC_LOW       21'h000018
`define TLIC_PEN_BIT       7
`define TLIC_HIGH_EN_BIT   7
`define TLIC_LOW_EN_BIT    6
`define TLIC_CTL_RST       2'h0
`define TLIC_PEN_RST       1'b0
// core clocks per instruction cycle and the external event latency
`define TLIC_CLK_PER_ICYC  4
`define TLIC_EXT_LAT_ICYC  3
`define TLIC_EXT_LAT_CLK   (`TLIC_CLK_PER_ICYC * `TLIC_EXT_LAT_ICYC)
`define TLIC_LAT_W         4
`define TLIC_LVL_NONE      2'h0
`define TLIC_LVL_LOW       2'h1
`define TLIC_LVL_HIGH      2'h2

`endif

// ---- design/tlic_flags.v ----
/*
 per-source sticky event flags.
 assumes event pulses and software clears are synchronous to clock_i.
*/
`timescale 1ns/1ps
`include "tlic_regs.vh"

module tlic_flags (
  input  wire                      clock_i,
  input  wire                      rst_i,
  input  wire [`TLIC_NSRC-1:0]     event_i,
  input  wire [`TLIC_NSRC-1:0]     clear_i,
  output wire [`TLIC_NSRC-1:0]     flag_o
);
  reg [`TLIC_NSRC-1:0] flag_ff;
  genvar g;
  generate
    for (g = 0; g < `TLIC_NSRC; g = g + 1) begin : g_flag
      always @(posedge clock_i) begin
        if (rst_i) begin
          flag_ff[g] <= 1'b0;
        end else if (event_i[g]) begin
          // set wins over clear; enables do not gate it
          flag_ff[g] <= 1'b1;
        end else if (clear_i[g]) begin
          flag_ff[g] <= 1'b0;
        end
      end
    end
  endgenerate
  assign flag_o = flag_ff;
endmodule

// ---- design/tlic_arb.v ----
/*
 combinational request arbitration between high and low levels.
 assumes flags, enables and priorities are registered upstream.
*/
`timescale 1ns/1ps
`include "tlic_regs.vh"

module tlic_arb (
  input  wire [`TLIC_NSRC-1:0]     flag_i,
  input  wire [`TLIC_NSRC-1:0]     enable_i,
  input  wire [`TLIC_NSRC-1:0]     prio_i,
  input  wire [`TLIC_NSRC-1:0]     periph_i,
  input  wire                      pen_i,
  input  wire                      bit7_i,
  input  wire                      bit6_i,
  input  wire                      in_high_i,
  output reg  [1:0]                level_o
);
  wire [`TLIC_NSRC-1:0] act = flag_i & enable_i;
  // priority bits ignored when levels are off
  wire hi_req  = pen_i & bit7_i & |(act & prio_i);
  wire lo_req  = pen_i & bit6_i & |(act & ~prio_i) & ~in_high_i;
  // compatibility: bit 7 gates all, bit 6 gates peripherals
  wire cmp_req = ~pen_i & bit7_i &
                 |(act & (~periph_i | {`TLIC_NSRC{bit6_i}}));
  always @* begin
    level_o = `TLIC_LVL_NONE;
    if (hi_req) begin
      level_o = `TLIC_LVL_HIGH;   // high first on a tie
    end else if (cmp_req) begin
      level_o = `TLIC_LVL_HIGH;   // single vector
    end else if (lo_req) begin
      level_o = `TLIC_LVL_LOW;
    end
  end
endmodule

// ---- dv/tlic_assertions.sv ----
/* port-level assertion checker for tlic_top.
   assumes one clock_i domain and the bind at the foot of this file. */
`timescale 1ns/1ps
`include "tlic_regs.vh"
module tlic_assertions (
  input wire        clock_i,
  input wire        rst_i,
  input wire        ret_instr_i,
  input wire [7:0]  event_i,
  input wire [7:0]  flag_o,
  input wire        priority_levels_enable_o,
  input wire        high_level_global_enable_o,
  input wire        low_level_global_enable_o,
  input wire        take_o,
  input wire [20:0] vector_o,
  input wire        in_high_o
);
  wire pl = priority_levels_enable_o;
  wire gh = high_level_global_enable_o;
  wire gl = low_level_global_enable_o;
  wire hi = take_o && vector_o == `TLIC_VEC_HIGH;
  wire lo = take_o && vector_o == `TLIC_VEC_LOW;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  AST_VEC: assert property (
    take_o |-> hi || lo) else $error("vector not a known target");
  AST_COMPAT: assert property (
    take_o && !pl |-> hi) else $error("compat take not high vector");
  AST_HCLR: assert property (
    hi |-> $fell(gh)) else $error("high enable not cleared");
  AST_LCLR: assert property (
    lo |-> $fell(gl)) else $error("low enable not cleared");
  AST_LPEN: assert property (
    lo |-> pl) else $error("low vector without levels");
  AST_NO_LOW: assert property (
    in_high_o && pl |-> !lo) else $error("low taken in high routine");
  AST_FLAG: assert property (
    |event_i |-> ##2 (flag_o & $past(event_i, 2)) == $past(event_i, 2))
    else $error("flag not set by event");
  AST_RET: assert property (
    ret_instr_i && (in_high_o || !pl) |-> ##[1:3] gh)
    else $error("return did not re-enable");
  AST_HOLD: assert property (
    !take_o |-> $stable(vector_o)) else $error("vector moved");
  AST_INH: assert property (
    hi |-> ##[0:1] in_high_o) else $error("high routine not flagged");
endmodule
bind tlic_top tlic_assertions u_chk (
  .clock_i(clock_i), .rst_i(rst_i), .ret_instr_i(ret_instr_i),
  .event_i(event_i), .flag_o(flag_o), .take_o(take_o),
  .priority_levels_enable_o(priority_levels_enable_o),
  .high_level_global_enable_o(high_level_global_enable_o),
  .low_level_global_enable_o(low_level_global_enable_o),
  .vector_o(vector_o), .in_high_o(in_high_o));

// ---- dv/tlic_core_model.sv ----
/* core fetch and stack model: loads the vector on take, returns on request.
   assumes take_i is a one-cycle pulse; pc holds still between branches. */
`timescale 1ns/1ps
module tlic_core_model (
  input  wire        clock_i,
  input  wire        rst_i,
  input  wire        take_i,
  input  wire [20:0] vector_i,
  input  wire        ret_req_i,
  output reg         ret_instr_o,
  output reg  [20:0] pc_o,
  output reg  [1:0]  depth_o
);
  reg [20:0] stack_ff [0:3];
  always @(posedge clock_i) begin
    ret_instr_o <= 1'b0;
    if (rst_i) begin
      pc_o <= 21'h000100;
      depth_o <= 2'h0;
    end else if (take_i) begin
      stack_ff[depth_o] <= pc_o;
      depth_o <= depth_o + 2'h1;
      pc_o <= vector_i;
    end else if (ret_req_i && depth_o != 2'h0) begin
      ret_instr_o <= 1'b1;
      depth_o <= depth_o - 2'h1;
      pc_o <= stack_ff[depth_o - 2'h1];
    end
  end
endmodule

// ---- dv/tlic_top_test.sv ----
/* self-checking bench for tlic_top with a core model on the far side.
   assumes the checker is bound in by its own file. */
`timescale 1ns/1ps
`include "tlic_regs.vh"
module tlic_top_test;
  reg         clock_i = 1'b0;
  reg         rst_i = 1'b1;
  reg  [7:0]  ev = 8'h00, clr = 8'h00, en = 8'h00, pr = 8'h00;
  reg  [7:0]  per = 8'h00, ext = 8'h00, ctl = 8'h00;
  reg         pen = 1'b0, wr = 1'b0, ret_req = 1'b0;
  wire [7:0]  flag;
  wire        pl, gh, gl, take, ih, il, ret_instr;
  wire [20:0] vec, pc;
  wire [1:0]  depth;
  integer     errors = 0, check_count = 0, lat;
  tlic_top uut (.clock_i(clock_i), .rst_i(rst_i), .event_i(ev),
    .flag_clear_i(clr), .enable_i(en), .prio_i(pr), .periph_i(per),
    .external_i(ext), .reset_ctl_wr_i(wr), .reset_ctl_data_i({pen, 7'h00}),
    .int_ctl_wr_i(wr), .int_ctl_data_i(ctl), .ret_instr_i(ret_instr),
    .flag_o(flag), .priority_levels_enable_o(pl),
    .high_level_global_enable_o(gh), .low_level_global_enable_o(gl),
    .take_o(take), .vector_o(vec), .in_high_o(ih), .in_low_o(il));
  tlic_core_model u_core (.clock_i(clock_i), .rst_i(rst_i), .take_i(take),
    .vector_i(vec), .ret_req_i(ret_req), .ret_instr_o(ret_instr), .pc_o(pc),
    .depth_o(depth));
  initial forever #4 clock_i = ~clock_i;
  task tick(input integer n);
    repeat (n) @(posedge clock_i);
  endtask
  task chk(input [20:0] e, input [20:0] a);
    check_count = check_count + 1;
    if (a !== e) begin
      errors = errors + 1;
      $display("unexpected at %0t: exp %h got %h", $time, e, a);
    end
  endtask
  task wctl(input [7:0] c);
    ctl <= c;
    wr <= 1'b1;
    tick(1);
    wr <= 1'b0;
  endtask
  task setup(input p, input [7:0] c, input [7:0] e, input [7:0] q);
    rst_i <= 1'b1;
    tick(4);
    rst_i <= 1'b0;
    pen <= p;
    en <= e;
    pr <= q;
    wctl(c);
    tick(1);
  endtask
  task fire(input [7:0] m);
    ev <= m;
    tick(1);
    ev <= 8'h00;
  endtask
  task clear(input [7:0] m);
    clr <= m;
    tick(1);
    clr <= 8'h00;
    tick(2);
  endtask
  task ret;
    ret_req <= 1'b1;
    tick(1);
    ret_req <= 1'b0;
  endtask
  // samples at the edge, so take seen here stood the cycle before
  task wt(input integer lim, input [20:0] v);
    lat = 0;
    while (take !== 1'b1 && lat < lim) begin
      tick(1);
      lat = lat + 1;
    end
    if (v == 21'h0) chk(0, take);
    else begin
      chk(1, take);
      chk(v, vec);
    end
  endtask
  task t_compat;
    per <= 8'h02;
    ext <= 8'h00;
    setup(1'b0, 8'hc0, 8'h03, 8'h00);
    fire(8'h02);
    wt(20, `TLIC_VEC_HIGH);
    tick(1);
    chk(0, gh);
    chk(`TLIC_VEC_HIGH, pc);
    chk(8'h02, flag);
    clear(8'h02);
    ret;
    tick(4);
    chk(1, gh);
    chk(0, depth);
    $display("compat test done");
  endtask
  task t_gate;
    setup(1'b0, 8'h80, 8'h03, 8'h00);
    fire(8'h06);
    wt(20, 0);
    chk(8'h06, flag);
    fire(8'h01);
    wt(20, `TLIC_VEC_HIGH);
    $display("gating test done");
  endtask
  task t_prio;
    per <= 8'h00;
    setup(1'b1, 8'h80, 8'h03, 8'h01);
    fire(8'h01);
    wt(20, `TLIC_VEC_HIGH);
    wctl(8'h40);
    fire(8'h02);
    wt(20, 0);
    clear(8'h01);
    ret;
    wt(20, `TLIC_VEC_LOW);
    tick(1);
    chk(0, gl);
    chk(1, gh);
    chk(1, il);
    chk(0, ih);
    chk(1, pl);
    fire(8'h01);
    wt(20, `TLIC_VEC_HIGH);
    tick(1);
    chk(2, depth);
    $display("priority test done");
  endtask
  task t_tie;
    setup(1'b1, 8'hc0, 8'h03, 8'h01);
    fire(8'h03);
    wt(20, `TLIC_VEC_HIGH);
    $display("tie test done");
  endtask
  task t_ext;
    ext <= 8'h04;
    setup(1'b0, 8'h80, 8'h04, 8'h00);
    fire(8'h04);
    wt(30, `TLIC_VEC_HIGH);
    chk(1, lat >= 12 && lat <= 16);
    $display("external latency test done");
  endtask
  task summarize;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    t_compat;
    t_gate;
    t_prio;
    t_tie;
    t_ext;
    summarize;
  end
  // all tests need well under a thousand cycles
  initial begin
    repeat (4000) @(posedge clock_i);
    errors = errors + 1;
    summarize;
  end
endmodule
